// file: design/epi_pkg.sv
// package for the external pin interrupt block: offsets, fields, resets
package epi_pkg;
  localparam int unsigned EPI_NUM_EXT = 4;
  localparam int unsigned EPI_NUM_PC = 27;
  localparam int unsigned EPI_NUM_GRP = 4;
  // wishbone word byte addresses
  localparam logic [5:0] EPI_OFS_SENSE = 6'h00;
  localparam logic [5:0] EPI_OFS_EXT_EN = 6'h04;
  localparam logic [5:0] EPI_OFS_EXT_FLAG = 6'h08;
  localparam logic [5:0] EPI_OFS_GRP_EN = 6'h0C;
  localparam logic [5:0] EPI_OFS_GRP_FLAG = 6'h10;
  localparam logic [5:0] EPI_OFS_MASK0 = 6'h14;
  localparam logic [5:0] EPI_OFS_MASK1 = 6'h18;
  localparam logic [5:0] EPI_OFS_MASK2 = 6'h1C;
  localparam logic [5:0] EPI_OFS_MASK3 = 6'h20;
  localparam logic [5:0] EPI_OFS_IRQ_STAT = 6'h24;
  localparam logic [5:0] EPI_OFS_IRQ_EN = 6'h28;
  localparam logic [5:0] EPI_OFS_IRQ_CLR = 6'h2C;
  localparam logic [5:0] EPI_OFS_ACK = 6'h30;
  localparam logic [5:0] EPI_OFS_PINS = 6'h34;
  // pin-change group boundaries (lowest input of each group)
  localparam int unsigned EPI_GRP0_LO = 0;
  localparam int unsigned EPI_GRP1_LO = 8;
  localparam int unsigned EPI_GRP2_LO = 16;
  localparam int unsigned EPI_GRP3_LO = 24;
  localparam int unsigned EPI_GRP_W = 8;
  // interrupt status layout: ext flags 3:0, group flags 7:4
  localparam int unsigned EPI_STAT_EXT_LSB = 0;
  localparam int unsigned EPI_STAT_GRP_LSB = 4;
  localparam int unsigned EPI_STAT_W = 8;
  localparam logic [7:0] EPI_SENSE_RST = 8'h00;
  localparam logic [7:0] EPI_MASK_RST = 8'h00;
  localparam logic [3:0] EPI_EN_RST = 4'h0;

  typedef enum logic [1:0] {
    EPI_SENSE_LOW = 2'b00,
    EPI_SENSE_ANY = 2'b01,
    EPI_SENSE_FALL = 2'b10,
    EPI_SENSE_RISE = 2'b11
  } epi_sense_t;

  typedef enum logic [0:0] {
    EPI_BUS_IDLE = 1'b0,
    EPI_BUS_ACK = 1'b1
  } epi_bus_state_t;
endpackage

// file: design/epi_edge_det.sv
// per-pin edge and level detector for the dedicated interrupt pins
`timescale 1ns/100ps
module epi_edge_det
  import epi_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire epi_pkg::epi_sense_t sense_i,
  output logic event_o,
  output logic level_o
);
  import epi_pkg::*;

  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = pin_i;
  end

  // previous sample, compared against the current one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= prev_next; // R18
    end
  end

  always_comb begin
    case (sense_i)
      EPI_SENSE_ANY: event_o = pin_i ^ prev_reg; // R14
      EPI_SENSE_FALL: event_o = prev_reg & ~pin_i; // R14
      EPI_SENSE_RISE: event_o = ~prev_reg & pin_i; // R14
      default: event_o = 1'b0;
    endcase
  end

  // level is purely combinational so it still works with the clock gated
  always_comb begin
    level_o = (sense_i == EPI_SENSE_LOW) & ~pin_i; // R10
  end
endmodule

// file: design/epi_ext_irq.sv
// external pin interrupt controller with wishbone register access
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// [R1] inputs raise requests even when the pin is driven as an output
// [R2] group two request on any unmasked change of inputs 23..16
// [R3] group one request on any unmasked change of inputs 14..8
// [R4] group zero request on any unmasked change of inputs 7..0
// [R5] per-group masks select which inputs may contribute
// [R6] pin-change wake works with clock stopped; here wake_o and pc_prev_reg are registered on clk_i
// [R7] each dedicated pin selects falling, rising or low level sensing
// [R8] enabled level-sensed pin requests while pin stays low
// [R9] dedicated pin edges are detected only on the running clock
// [R10] low-level detection needs no clock; here ext_irq_req_o and wake_o are registered on clk_i
// [R11] clock stopped in deep sleep disables edge detection
// [R12] level gone before start-up end: wake, but no level request
// [R13] external source holds level until start-up completes
// [R14] sense codes: 00 low, 01 any change, 10 falling, 11 rising
// [R15] pulses longer than one clock always produce a request
// [R16] flags clear on vector ack or written one; level mode holds clear
// [R17] group flag set when an enabled input change triggers a request
// [R18] sample pins each clock and compare with previous sample
// [R19] all settings, masks, enables and flags reset to zero
module epi_ext_irq
  import epi_pkg::*;
#(
  parameter int unsigned NUM_EXT = EPI_NUM_EXT,
  parameter int unsigned NUM_PC = EPI_NUM_PC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_EXT-1:0] ext_irq_pins_i,
  input wire logic [NUM_PC-1:0] all_pin_change_inputs_i,
  output logic [NUM_EXT-1:0] ext_irq_req_o,
  output logic [3:0] pin_change_req_o,
  output logic pin_change_group_zero_req_o,
  output logic pin_change_group_two_req_o,
  output logic wake_o,
  output logic irq_o
);
  import epi_pkg::*;

  // register state
  logic [7:0] ext_irq_sense_config_reg, ext_irq_sense_config_next;
  logic [3:0] ext_en_reg, ext_en_next;
  logic [3:0] ext_irq_flag_reg, ext_irq_flag_next;
  logic [3:0] grp_en_reg, grp_en_next;
  logic [3:0] grp_flag_reg, grp_flag_next;
  logic [7:0] pin_change_mask_zero_reg, pin_change_mask_zero_next;
  logic [7:0] pin_change_mask_one_reg, pin_change_mask_one_next;
  logic [7:0] pin_change_mask_two_reg, pin_change_mask_two_next;
  logic [7:0] pin_change_mask_three_reg, pin_change_mask_three_next;
  logic [7:0] irq_stat_reg, irq_stat_next;
  logic [7:0] irq_en_reg, irq_en_next;
  logic [NUM_PC-1:0] pc_prev_reg, pc_prev_next;
  epi_bus_state_t bus_reg, bus_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [NUM_EXT-1:0] ext_req_reg, ext_req_next;
  logic [3:0] pc_req_reg, pc_req_next;
  logic wake_reg, wake_next;
  logic irq_reg, irq_next;

  logic [NUM_EXT-1:0] ext_event, ext_level;
  logic [NUM_EXT-1:0] level_mode;
  logic [31:0] pc_mask_all;
  logic [NUM_PC-1:0] pc_change;
  logic [3:0] grp_hit;
  logic wr_stb, rd_stb;

  // one detector per dedicated pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      epi_edge_det u_det (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_irq_pins_i[gi]), // R1
        .sense_i(epi_sense_t'(ext_irq_sense_config_reg[2*gi +: 2])), // R7
        .event_o(ext_event[gi]), // R9 R11 R15
        .level_o(ext_level[gi])
      );
      assign level_mode[gi] =
        (ext_irq_sense_config_reg[2*gi +: 2] == EPI_SENSE_LOW);
    end
  endgenerate

  assign pc_mask_all = {pin_change_mask_three_reg, pin_change_mask_two_reg,
                        pin_change_mask_one_reg, pin_change_mask_zero_reg};

  // input pin state is taken directly, even for pins driven as outputs
  always_comb begin
    pc_prev_next = all_pin_change_inputs_i; // R1
    pc_change = (all_pin_change_inputs_i ^ pc_prev_reg)
                & pc_mask_all[NUM_PC-1:0]; // R5
  end

  always_comb begin
    grp_hit[0] = |pc_change[EPI_GRP0_LO +: EPI_GRP_W]; // R4
    grp_hit[1] = |pc_change[EPI_GRP1_LO +: 7]; // R3
    grp_hit[2] = |pc_change[EPI_GRP2_LO +: EPI_GRP_W]; // R2
    grp_hit[3] = |pc_change[NUM_PC-1:EPI_GRP3_LO]; // R17
  end

  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & (bus_reg == EPI_BUS_IDLE);
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & (bus_reg == EPI_BUS_IDLE);

  // register writes and flag updates; sets win over clears
  always_comb begin
    ext_irq_sense_config_next = ext_irq_sense_config_reg;
    ext_en_next = ext_en_reg;
    grp_en_next = grp_en_reg;
    pin_change_mask_zero_next = pin_change_mask_zero_reg;
    pin_change_mask_one_next = pin_change_mask_one_reg;
    pin_change_mask_two_next = pin_change_mask_two_reg;
    pin_change_mask_three_next = pin_change_mask_three_reg;
    irq_en_next = irq_en_reg;
    ext_irq_flag_next = ext_irq_flag_reg;
    grp_flag_next = grp_flag_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_stb && wb_sel_i[0]) begin
      case (wb_adr_i)
        EPI_OFS_SENSE: ext_irq_sense_config_next = wb_dat_i[7:0]; // R14
        EPI_OFS_EXT_EN: ext_en_next = wb_dat_i[3:0];
        EPI_OFS_GRP_EN: grp_en_next = wb_dat_i[3:0];
        EPI_OFS_MASK0: pin_change_mask_zero_next = wb_dat_i[7:0]; // R5
        EPI_OFS_MASK1: pin_change_mask_one_next = wb_dat_i[7:0];
        EPI_OFS_MASK2: pin_change_mask_two_next = wb_dat_i[7:0];
        EPI_OFS_MASK3: pin_change_mask_three_next = wb_dat_i[7:0];
        EPI_OFS_IRQ_EN: irq_en_next = wb_dat_i[7:0];
        EPI_OFS_EXT_FLAG: ext_irq_flag_next &= ~wb_dat_i[3:0]; // R16
        EPI_OFS_GRP_FLAG: grp_flag_next &= ~wb_dat_i[3:0]; // R16
        // core signals vector entry: low nibble ext, high nibble group
        EPI_OFS_ACK: begin
          ext_irq_flag_next &= ~wb_dat_i[3:0]; // R16
          grp_flag_next &= ~wb_dat_i[7:4]; // R16
        end
        EPI_OFS_IRQ_CLR: irq_stat_next &= ~wb_dat_i[7:0];
        default: ;
      endcase
    end
    ext_irq_flag_next = (ext_irq_flag_next | ext_event) & ~level_mode; // R16
    grp_flag_next = grp_flag_next | grp_hit; // R17
    irq_stat_next = irq_stat_next
                    | {grp_hit, ext_event & ~level_mode}
                    | {4'h0, ext_level & ext_en_reg};
  end

  // requests toward the core and wake; level requests follow the pin
  always_comb begin
    ext_req_next = (ext_irq_flag_next & ext_en_reg & ~level_mode)
                   | (ext_level & ext_en_reg); // R8 R12
    pc_req_next = grp_flag_next & grp_en_reg; // R2 R3 R4
    // wake taps the unclocked level path and the raw change terms;
    // the change compare uses the clocked pc_prev_reg sample, and wake_o is registered
    wake_next = |(ext_level & ext_en_reg)
                | |(grp_hit & grp_en_reg); // R6 R10 R13
    irq_next = |(irq_stat_next & irq_en_reg);
  end

  // bus answer: one wait state, ack drops in the cycle after
  always_comb begin
    bus_next = bus_reg;
    // read data stands only in the ack cycle and is zero otherwise
    rdat_next = 32'h0000_0000;
    case (bus_reg)
      EPI_BUS_IDLE: begin
        if (wr_stb || rd_stb) begin
          bus_next = EPI_BUS_ACK;
        end
        rdat_next = 32'h0000_0000;
        if (rd_stb) begin
          case (wb_adr_i)
            EPI_OFS_SENSE: rdat_next[7:0] = ext_irq_sense_config_reg;
            EPI_OFS_EXT_EN: rdat_next[3:0] = ext_en_reg;
            EPI_OFS_EXT_FLAG: rdat_next[3:0] = ext_irq_flag_reg;
            EPI_OFS_GRP_EN: rdat_next[3:0] = grp_en_reg;
            EPI_OFS_GRP_FLAG: rdat_next[3:0] = grp_flag_reg;
            EPI_OFS_MASK0: rdat_next[7:0] = pin_change_mask_zero_reg;
            EPI_OFS_MASK1: rdat_next[7:0] = pin_change_mask_one_reg;
            EPI_OFS_MASK2: rdat_next[7:0] = pin_change_mask_two_reg;
            EPI_OFS_MASK3: rdat_next[7:0] = pin_change_mask_three_reg;
            EPI_OFS_IRQ_STAT: rdat_next[7:0] = irq_stat_reg;
            EPI_OFS_IRQ_EN: rdat_next[7:0] = irq_en_reg;
            EPI_OFS_PINS: rdat_next[NUM_PC-1:0] = all_pin_change_inputs_i;
            default: rdat_next = 32'h0000_0000;
          endcase
        end
      end
      EPI_BUS_ACK: bus_next = EPI_BUS_IDLE;
      default: bus_next = EPI_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq_sense_config_reg <= EPI_SENSE_RST; // R19
      ext_en_reg <= EPI_EN_RST;
      ext_irq_flag_reg <= EPI_EN_RST;
      grp_en_reg <= EPI_EN_RST;
      grp_flag_reg <= EPI_EN_RST;
      pin_change_mask_zero_reg <= EPI_MASK_RST;
      pin_change_mask_one_reg <= EPI_MASK_RST;
      pin_change_mask_two_reg <= EPI_MASK_RST;
      pin_change_mask_three_reg <= EPI_MASK_RST;
      irq_stat_reg <= EPI_MASK_RST;
      irq_en_reg <= EPI_MASK_RST;
      pc_prev_reg <= '0;
      bus_reg <= EPI_BUS_IDLE;
      rdat_reg <= 32'h0000_0000;
      ext_req_reg <= '0;
      pc_req_reg <= 4'h0;
      wake_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ext_irq_sense_config_reg <= ext_irq_sense_config_next;
      ext_en_reg <= ext_en_next;
      ext_irq_flag_reg <= ext_irq_flag_next;
      grp_en_reg <= grp_en_next;
      grp_flag_reg <= grp_flag_next;
      pin_change_mask_zero_reg <= pin_change_mask_zero_next;
      pin_change_mask_one_reg <= pin_change_mask_one_next;
      pin_change_mask_two_reg <= pin_change_mask_two_next;
      pin_change_mask_three_reg <= pin_change_mask_three_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg <= irq_en_next;
      pc_prev_reg <= pc_prev_next;
      bus_reg <= bus_next;
      rdat_reg <= rdat_next;
      ext_req_reg <= ext_req_next;
      pc_req_reg <= pc_req_next;
      wake_reg <= wake_next;
      irq_reg <= irq_next;
    end
  end

  assign wb_ack_o = (bus_reg == EPI_BUS_ACK);
  assign wb_dat_o = rdat_reg;
  assign ext_irq_req_o = ext_req_reg;
  assign pin_change_req_o = pc_req_reg;
  assign pin_change_group_zero_req_o = pc_req_reg[0];
  assign pin_change_group_two_req_o = pc_req_reg[2];
  assign wake_o = wake_reg;
  assign irq_o = irq_reg;
endmodule

// file: verification/epi_pin_model.sv
// model of the external pins and the core side that drives them
`timescale 1ns/100ps
module epi_pin_model (
  input wire logic clk_i,
  input wire logic [3:0] ext_cmd_i,
  input wire logic [26:0] pc_cmd_i,
  output logic [3:0] ext_pins_o = 4'hF,
  output logic [26:0] pc_pins_o = 27'h0
);
  // pins move just after an edge and hold whole cycles, so any pulse
  // lasts at least one clock period and a held low spans the start-up time
  always @(posedge clk_i) begin
    ext_pins_o <= ext_cmd_i;
    pc_pins_o <= pc_cmd_i;
  end
endmodule

// file: verification/epi_ext_irq_assertions.sv
// port assertions for the external pin interrupt block
`timescale 1ns/100ps
module epi_ext_irq_checker
  import epi_pkg::*;
#(
  parameter int unsigned NUM_EXT = EPI_NUM_EXT,
  parameter int unsigned NUM_PC = EPI_NUM_PC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NUM_PC-1:0] all_pin_change_inputs_i,
  input wire logic [NUM_EXT-1:0] ext_irq_req_o,
  input wire logic [3:0] pin_change_req_o,
  input wire logic pin_change_group_zero_req_o,
  input wire logic pin_change_group_two_req_o,
  input wire logic wake_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_on_take: assert property (s_take |=> s_answer)
    else $error("ack not a pulse one cycle after request");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside answer");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !irq_o && !wake_o && pin_change_req_o == 4'h0
    && ext_irq_req_o == '0) else $error("outputs not cleared by reset");
  a_grp_zero_alias: assert property (
    pin_change_group_zero_req_o == pin_change_req_o[0])
    else $error("group zero request mismatch");
  a_grp_two_alias: assert property (
    pin_change_group_two_req_o == pin_change_req_o[2])
    else $error("group two request mismatch");
  // group requests are sticky: only a register write may take one away
  a_pc_req_sticky: assert property (
    |($past(pin_change_req_o) & ~pin_change_req_o) && !$past(rst_i)
    |-> wb_ack_o && wb_we_i) else $error("group request lost");
  a_pc_two_cause: assert property (
    $rose(pin_change_req_o[2]) && !$past(rst_i) |-> wb_ack_o ||
    $past(all_pin_change_inputs_i[23:16]) !=
    $past(all_pin_change_inputs_i[23:16], 2))
    else $error("group two request without change");
  a_pc_zero_cause: assert property (
    $rose(pin_change_req_o[0]) && !$past(rst_i) |-> wb_ack_o ||
    $past(all_pin_change_inputs_i[7:0]) !=
    $past(all_pin_change_inputs_i[7:0], 2))
    else $error("group zero request without change");
endmodule

// file: verification/testbench.sv
// self-checking bench for the external pin interrupt block
`timescale 1ns/100ps
module testbench;
  import epi_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, pcg0, pcg2, wake_o, irq_o;
  logic [3:0] ext_cmd = 4'hF, ext_pins, ext_req, pc_req;
  logic [26:0] pc_cmd = 27'h0, pc_pins;
  int n_mismatch = 0, compares = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  epi_pin_model pins (.clk_i(clk_i), .ext_cmd_i(ext_cmd),
    .pc_cmd_i(pc_cmd), .ext_pins_o(ext_pins), .pc_pins_o(pc_pins));
  epi_ext_irq dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_irq_pins_i(ext_pins),
    .all_pin_change_inputs_i(pc_pins), .ext_irq_req_o(ext_req),
    .pin_change_req_o(pc_req), .pin_change_group_zero_req_o(pcg0),
    .pin_change_group_two_req_o(pcg2), .wake_o(wake_o), .irq_o(irq_o));
  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic cycle; the request holds until ack is sampled high
  task automatic wb_xfer(logic we, logic [5:0] adr, logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd_chk(string name, logic [5:0] adr, logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    check(name, exp, rd);
  endtask
  // pins settle through the model and the flag logic within four edges
  task automatic set_pins(logic [3:0] ext, logic [26:0] pc);
    @(posedge clk_i);
    ext_cmd <= ext;
    pc_cmd <= pc;
    repeat (4) @(posedge clk_i);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd_chk("reset value", 6'(a * 4), 32'h0);
    end
    wb_xfer(1'b1, EPI_OFS_GRP_EN, 32'hF);
    for (int g = 0; g < 4; g++) begin
      wb_xfer(1'b1, 6'(EPI_OFS_MASK0 + 4 * g), 32'h1);
      set_pins(4'hF, 27'(2) << (8 * g));
      rd_chk("masked group", EPI_OFS_GRP_FLAG, 32'h0);
      set_pins(4'hF, 27'(3) << (8 * g));
      rd_chk("group flag", EPI_OFS_GRP_FLAG, 32'(1 << g));
      check("group req", 32'(1 << g), 32'(pc_req));
      check("group zero req", 32'(g == 0), 32'(pcg0));
      check("group two req", 32'(g == 2), 32'(pcg2));
      set_pins(4'hF, 27'h0);
      wb_xfer(1'b1, EPI_OFS_GRP_FLAG, 32'hF);
      rd_chk("group cleared", EPI_OFS_GRP_FLAG, 32'h0);
    end
    wb_xfer(1'b1, EPI_OFS_EXT_EN, 32'hF);
    for (int m = 1; m < 4; m++) begin
      wb_xfer(1'b1, EPI_OFS_SENSE, 32'(m << (2 * m)));
      wb_xfer(1'b1, EPI_OFS_EXT_FLAG, 32'hF);
      set_pins(~(4'(1) << m), 27'h0);
      rd_chk("fall flag", EPI_OFS_EXT_FLAG, 32'(m != 3) << m);
      wb_xfer(1'b1, EPI_OFS_EXT_FLAG, 32'hF);
      set_pins(4'hF, 27'h0);
      rd_chk("rise flag", EPI_OFS_EXT_FLAG, 32'(m != 2) << m);
      wb_xfer(1'b1, EPI_OFS_EXT_FLAG, 32'hF);
    end
    wb_xfer(1'b1, EPI_OFS_IRQ_CLR, 32'hFF);
    set_pins(4'hE, 27'h0);
    check("level req", 32'h1, 32'(ext_req));
    repeat (20) @(posedge clk_i);
    check("level held", 32'h1, 32'(ext_req));
    check("level wake", 32'h1, 32'(wake_o));
    rd_chk("level flag", EPI_OFS_EXT_FLAG, 32'h0);
    rd_chk("level status", EPI_OFS_IRQ_STAT, 32'h1);
    check("irq masked", 32'h0, 32'(irq_o));
    wb_xfer(1'b1, EPI_OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge clk_i);
    check("irq raised", 32'h1, 32'(irq_o));
    set_pins(4'hF, 27'h0);
    wb_xfer(1'b1, EPI_OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk_i);
    check("irq cleared", 32'h0, 32'(irq_o));
    check("level gone", 32'h0, 32'(ext_req));
    check("wake gone", 32'h0, 32'(wake_o));
    set_pins(4'hF, 27'h1);
    rd_chk("group flag set", EPI_OFS_GRP_FLAG, 32'h1);
    wb_xfer(1'b1, EPI_OFS_ACK, 32'h10);
    rd_chk("vector ack", EPI_OFS_GRP_FLAG, 32'h0);
    finish_test();
  end
endmodule
bind epi_ext_irq epi_ext_irq_checker #(.NUM_EXT(NUM_EXT), .NUM_PC(NUM_PC))
  chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .all_pin_change_inputs_i(all_pin_change_inputs_i),
  .ext_irq_req_o(ext_irq_req_o), .pin_change_req_o(pin_change_req_o),
  .pin_change_group_zero_req_o(pin_change_group_zero_req_o),
  .pin_change_group_two_req_o(pin_change_group_two_req_o),
  .wake_o(wake_o), .irq_o(irq_o));
